/* File: ledctl_map.svh */
// register offsets, field widths, reset values and bit positions of the control bank
`ifndef LEDCTL_MAP_SVH
`define LEDCTL_MAP_SVH

// ----------------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------------
`define LEDCTL_ADDR_STATUS3 8'h05
`define LEDCTL_ADDR_TW_LIMIT 8'h06
`define LEDCTL_ADDR_SLEEP 8'h07
`define LEDCTL_ADDR_CH1_CUR_LO 8'h08
`define LEDCTL_ADDR_CH1_CUR_HI 8'h09
`define LEDCTL_ADDR_CH2_CUR_LO 8'h0a
`define LEDCTL_ADDR_CH2_CUR_HI 8'h0b
`define LEDCTL_ADDR_DIM_DIV 8'h0c
`define LEDCTL_ADDR_CH1_DIM_LO 8'h0d
`define LEDCTL_ADDR_CH1_DIM_HI 8'h0e
`define LEDCTL_ADDR_CH2_DIM_LO 8'h0f
`define LEDCTL_ADDR_CH2_DIM_HI 8'h10
`define LEDCTL_ADDR_CH1_ON 8'h11
`define LEDCTL_ADDR_CH2_ON 8'h12
`define LEDCTL_REG_COUNT 13

// ----------------------------------------------------------------------------
// implemented field widths (bits above read as zero)
// ----------------------------------------------------------------------------
`define LEDCTL_W_TW_LIMIT 8
`define LEDCTL_W_SLEEP 2
`define LEDCTL_W_CUR_LO 2
`define LEDCTL_W_CUR_HI 8
`define LEDCTL_W_DIM_DIV 3
`define LEDCTL_W_DIM_LO 8
`define LEDCTL_W_DIM_HI 2
`define LEDCTL_W_ON 6

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define LEDCTL_RST_TW_LIMIT 8'h8a
`define LEDCTL_RST_SLEEP 8'h00
`define LEDCTL_RST_CUR 8'h00
`define LEDCTL_RST_DIM_DIV 8'h04
`define LEDCTL_RST_DIM 8'h00
`define LEDCTL_RST_ON 8'h07

// ----------------------------------------------------------------------------
// status bit position of the thermal warning flag
// ----------------------------------------------------------------------------
`define LEDCTL_TW_BIT 3

`endif

/* File: ledctl_pkg.sv */
// types shared by the led driver control register bank
package ledctl_pkg;

   typedef logic [7:0] byte_t;

   // sleep field commands; the two upper codes leave the state alone
   typedef enum logic [1:0] {
      SLEEP_EXIT = 2'b00,
      SLEEP_ENTER = 2'b01,
      SLEEP_HOLD_A = 2'b10,
      SLEEP_HOLD_B = 2'b11
   } sleep_cmd_e;

endpackage

/* File: ctrl_field_reg.sv */
// one byte-wide control register holding a field of WIDTH low bits
`timescale 1ns/1ps

module ctrl_field_reg #(
   parameter int unsigned WIDTH = 8,
   parameter logic [7:0] ADDR = 8'h00,
   parameter logic [7:0] RESET = 8'h00
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic wr_en,
   input wire ledctl_pkg::byte_t addr,
   input wire ledctl_pkg::byte_t wdata,
   output ledctl_pkg::byte_t value
);
   import ledctl_pkg::*;

   // bits above the field are held at zero so they read back as zero
   localparam byte_t MASK = byte_t'((9'h001 << WIDTH) - 9'h001);

   // ----------------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------------
   // only a write aimed at this offset touches the value
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         value <= RESET & MASK;
      end else if (wr_en && (addr == ADDR)) begin
         value <= wdata & MASK;
      end
   end

endmodule // ctrl_field_reg

/* File: led_driver_control_regs.sv */
// control register bank of a dual-channel buck led driver, with thermal warning flag
`timescale 1ns/1ps
`include "ledctl_map.svh"

module led_driver_control_regs (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire ledctl_pkg::byte_t reg_wdata,
   output ledctl_pkg::byte_t reg_rdata,
   input wire logic temp_valid,
   input wire logic [9:0] temp_adc,
   output logic thermal_warn_flag,
   output logic sleep_active,
   output logic [9:0] ch1_current_set_value,
   output logic [9:0] ch2_current_set_value,
   output logic [2:0] dimming_clock_divider,
   output logic [9:0] ch1_dim_width,
   output logic [9:0] ch2_dim_width,
   output logic [5:0] ch1_on_time,
   output logic [5:0] ch2_on_time
);
   import ledctl_pkg::*;

   // ----------------------------------------------------------------------------
   // register table: entry i sits at offset 0x06 + i
   // ----------------------------------------------------------------------------
   localparam int N = `LEDCTL_REG_COUNT;
   localparam byte_t ADDRS [N] = '{
      `LEDCTL_ADDR_TW_LIMIT, `LEDCTL_ADDR_SLEEP,
      `LEDCTL_ADDR_CH1_CUR_LO, `LEDCTL_ADDR_CH1_CUR_HI,
      `LEDCTL_ADDR_CH2_CUR_LO, `LEDCTL_ADDR_CH2_CUR_HI,
      `LEDCTL_ADDR_DIM_DIV,
      `LEDCTL_ADDR_CH1_DIM_LO, `LEDCTL_ADDR_CH1_DIM_HI,
      `LEDCTL_ADDR_CH2_DIM_LO, `LEDCTL_ADDR_CH2_DIM_HI,
      `LEDCTL_ADDR_CH1_ON, `LEDCTL_ADDR_CH2_ON
   };
   localparam int unsigned WIDTHS [N] = '{
      `LEDCTL_W_TW_LIMIT, `LEDCTL_W_SLEEP,
      `LEDCTL_W_CUR_LO, `LEDCTL_W_CUR_HI,
      `LEDCTL_W_CUR_LO, `LEDCTL_W_CUR_HI,
      `LEDCTL_W_DIM_DIV,
      `LEDCTL_W_DIM_LO, `LEDCTL_W_DIM_HI,
      `LEDCTL_W_DIM_LO, `LEDCTL_W_DIM_HI,
      `LEDCTL_W_ON, `LEDCTL_W_ON
   };
   localparam byte_t RESETS [N] = '{
      `LEDCTL_RST_TW_LIMIT, `LEDCTL_RST_SLEEP,
      `LEDCTL_RST_CUR, `LEDCTL_RST_CUR,
      `LEDCTL_RST_CUR, `LEDCTL_RST_CUR,
      `LEDCTL_RST_DIM_DIV,
      `LEDCTL_RST_DIM, `LEDCTL_RST_DIM,
      `LEDCTL_RST_DIM, `LEDCTL_RST_DIM,
      `LEDCTL_RST_ON, `LEDCTL_RST_ON
   };

   byte_t reg_value [N];
   byte_t next_rdata;
   logic tw_set;
   logic tw_clear;
   logic sleep_write;

   // ----------------------------------------------------------------------------
   // storage, one field register per offset
   // ----------------------------------------------------------------------------
   // a write lands only in the register whose offset matches, so the two halves
   // of a split value are independent and unshadowed
   for (genvar i = 0; i < N; i++) begin : g_reg
      ctrl_field_reg #(
         .WIDTH(WIDTHS[i]),
         .ADDR(ADDRS[i]),
         .RESET(RESETS[i])
      ) u_field (
         .clock(clock),
         .sys_rst(sys_rst),
         .wr_en(reg_wr_en),
         .addr(reg_addr),
         .wdata(reg_wdata),
         .value(reg_value[i])
      );
   end

   // ----------------------------------------------------------------------------
   // values presented to the analog and dimming logic
   // ----------------------------------------------------------------------------
   // current: high register carries bits 9:2, low register bits 1:0
   assign ch1_current_set_value = {reg_value[3], reg_value[2][1:0]};
   assign ch2_current_set_value = {reg_value[5], reg_value[4][1:0]};
   assign dimming_clock_divider = reg_value[6][2:0];
   // dimming width: low register bits 7:0, high register bits 9:8
   assign ch1_dim_width = {reg_value[8][1:0], reg_value[7]};
   assign ch2_dim_width = {reg_value[10][1:0], reg_value[9]};
   assign ch1_on_time = reg_value[11][5:0];
   assign ch2_on_time = reg_value[12][5:0];

   // ----------------------------------------------------------------------------
   // sleep state
   // ----------------------------------------------------------------------------
   assign sleep_write = reg_wr_en && (reg_addr == `LEDCTL_ADDR_SLEEP);

   // the field keeps what was written; the state moves only on the two live codes
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sleep_active <= 1'b0;
      end else if (sleep_write) begin
         unique case (sleep_cmd_e'(reg_wdata[1:0]))
            SLEEP_EXIT: sleep_active <= 1'b0;
            SLEEP_ENTER: sleep_active <= 1'b1;
            SLEEP_HOLD_A: sleep_active <= sleep_active;
            SLEEP_HOLD_B: sleep_active <= sleep_active;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // thermal warning
   // ----------------------------------------------------------------------------
   // only the top byte of the conversion is compared, so the limit has 4-lsb steps
   assign tw_set = temp_valid && (temp_adc[9:2] > reg_value[0]);
   assign tw_clear = reg_rd_en && (reg_addr == `LEDCTL_ADDR_STATUS3);

   // sticky flag; a new over-limit sample beats a clearing read in the same cycle
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         thermal_warn_flag <= 1'b0;
      end else if (tw_set) begin
         thermal_warn_flag <= 1'b1;
      end else if (tw_clear) begin
         thermal_warn_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------------------
   // unmapped offsets answer zero; status shows only the flag this bank owns
   always_comb begin
      next_rdata = 8'h00;
      if (reg_addr == `LEDCTL_ADDR_STATUS3) begin
         next_rdata[`LEDCTL_TW_BIT] = thermal_warn_flag;
      end
      for (int k = 0; k < N; k++) begin
         if (reg_addr == ADDRS[k]) begin
            next_rdata = reg_value[k];
         end
      end
   end

   // read data held until the next read so the frame logic can shift it out
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd_en) begin
         reg_rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------------
   property p_tw_sets;
      @(posedge clock) disable iff (sys_rst)
      (temp_valid && (temp_adc[9:2] > reg_value[0])) |=> thermal_warn_flag;
   endproperty
   a_tw_sets: assert property (p_tw_sets)
      else $error("thermal flag not set after over-limit sample");

   property p_tw_quiet;
      @(posedge clock) disable iff (sys_rst)
      (!thermal_warn_flag && !(temp_valid && (temp_adc[9:2] > reg_value[0])))
         |=> !thermal_warn_flag;
   endproperty
   a_tw_quiet: assert property (p_tw_quiet)
      else $error("thermal flag rose without an over-limit sample");

   property p_tw_read_clears;
      @(posedge clock) disable iff (sys_rst)
      (reg_rd_en && reg_addr == `LEDCTL_ADDR_STATUS3 && !tw_set)
         |=> !thermal_warn_flag && (reg_rdata[`LEDCTL_TW_BIT] == $past(thermal_warn_flag))
             && (reg_rdata[7:4] == 4'h0);
   endproperty
   a_tw_read_clears: assert property (p_tw_read_clears)
      else $error("status read did not report and clear the thermal flag");

   property p_limit_reset;
      @(posedge clock) disable iff (sys_rst)
      $fell(sys_rst) |-> (reg_value[0] == 8'h8a) && !sleep_active
         && (ch1_current_set_value == 10'h000) && (ch2_current_set_value == 10'h000);
   endproperty
   a_limit_reset: assert property (p_limit_reset)
      else $error("bank did not come out of reset with its reset values");

   property p_sleep_enter;
      @(posedge clock) disable iff (sys_rst)
      (sleep_write && reg_wdata[1:0] == 2'b01)
         |=> sleep_active ##1 (sleep_active || $past(sleep_write));
   endproperty
   a_sleep_enter: assert property (p_sleep_enter)
      else $error("sleep not entered after writing 01");

   property p_sleep_exit;
      @(posedge clock) disable iff (sys_rst)
      (sleep_write && reg_wdata[1:0] == 2'b00) |=> !sleep_active;
   endproperty
   a_sleep_exit: assert property (p_sleep_exit)
      else $error("sleep not left after writing 00");

   property p_sleep_hold;
      @(posedge clock) disable iff (sys_rst)
      (sleep_write && reg_wdata[1]) |=> $stable(sleep_active)
         && (reg_value[1] == {6'h00, $past(reg_wdata[1:0])});
   endproperty
   a_sleep_hold: assert property (p_sleep_hold)
      else $error("sleep state changed on a no-effect code");

   property p_cur_high_only;
      @(posedge clock) disable iff (sys_rst)
      (reg_wr_en && reg_addr == `LEDCTL_ADDR_CH1_CUR_HI)
         |=> (ch1_current_set_value[9:2] == $past(reg_wdata))
             && (ch1_current_set_value[1:0] == $past(ch1_current_set_value[1:0]));
   endproperty
   a_cur_high_only: assert property (p_cur_high_only)
      else $error("current high write did not land in bits 9:2 alone");

   property p_cur_low_reserved;
      @(posedge clock) disable iff (sys_rst)
      (reg_wr_en && reg_addr == `LEDCTL_ADDR_CH2_CUR_LO) ##1
         (reg_rd_en && !reg_wr_en && reg_addr == `LEDCTL_ADDR_CH2_CUR_LO)
         |=> reg_rdata == {6'h00, $past(reg_wdata[1:0], 2)};
   endproperty
   a_cur_low_reserved: assert property (p_cur_low_reserved)
      else $error("current low register read back wrong or with reserved bits");

   property p_limit_readback;
      @(posedge clock) disable iff (sys_rst)
      (reg_wr_en && reg_addr == `LEDCTL_ADDR_TW_LIMIT) ##1
         (reg_rd_en && !reg_wr_en && reg_addr == `LEDCTL_ADDR_TW_LIMIT)
         |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_limit_readback: assert property (p_limit_readback)
      else $error("thermal limit did not read back what was written");

   property p_divider;
      @(posedge clock) disable iff (sys_rst)
      (reg_wr_en && reg_addr == `LEDCTL_ADDR_DIM_DIV)
         |=> (dimming_clock_divider == $past(reg_wdata[2:0])) && (reg_value[6][7:3] == 5'h00);
   endproperty
   a_divider: assert property (p_divider)
      else $error("divider write not applied");

   property p_dim_width_high;
      @(posedge clock) disable iff (sys_rst)
      (reg_wr_en && reg_addr == `LEDCTL_ADDR_CH1_DIM_HI)
         |=> (ch1_dim_width[9:8] == $past(reg_wdata[1:0]))
             && (ch1_dim_width[7:0] == $past(ch1_dim_width[7:0]));
   endproperty
   a_dim_width_high: assert property (p_dim_width_high)
      else $error("dimming width high write misplaced");

   property p_dim_width_ch2;
      @(posedge clock) disable iff (sys_rst)
      (reg_wr_en && reg_addr == `LEDCTL_ADDR_CH2_DIM_LO)
         |=> ch2_dim_width[7:0] == $past(reg_wdata);
   endproperty
   a_dim_width_ch2: assert property (p_dim_width_ch2)
      else $error("channel 2 dimming width low write misplaced");

   property p_on_time;
      @(posedge clock) disable iff (sys_rst)
      (reg_wr_en && reg_addr == `LEDCTL_ADDR_CH2_ON) |=> ch2_on_time == $past(reg_wdata[5:0]);
   endproperty
   a_on_time: assert property (p_on_time)
      else $error("channel 2 on-time write not applied");

   property p_on_time_ch1;
      @(posedge clock) disable iff (sys_rst)
      (reg_wr_en && reg_addr == `LEDCTL_ADDR_CH1_ON) |=> ch1_on_time == $past(reg_wdata[5:0]);
   endproperty
   a_on_time_ch1: assert property (p_on_time_ch1)
      else $error("channel 1 on-time write not applied");

   property p_cur_low_only;
      @(posedge clock) disable iff (sys_rst)
      (reg_wr_en && reg_addr == `LEDCTL_ADDR_CH1_CUR_LO)
         |=> (ch1_current_set_value[1:0] == $past(reg_wdata[1:0]))
             && (ch1_current_set_value[9:2] == $past(ch1_current_set_value[9:2]));
   endproperty
   a_cur_low_only: assert property (p_cur_low_only)
      else $error("current low write did not land in bits 1:0 alone");

   property p_cur_ch2_high;
      @(posedge clock) disable iff (sys_rst)
      (reg_wr_en && reg_addr == `LEDCTL_ADDR_CH2_CUR_HI)
         |=> ch2_current_set_value[9:2] == $past(reg_wdata);
   endproperty
   a_cur_ch2_high: assert property (p_cur_ch2_high)
      else $error("channel 2 current high write misplaced");

   property p_dim_width_low;
      @(posedge clock) disable iff (sys_rst)
      (reg_wr_en && reg_addr == `LEDCTL_ADDR_CH1_DIM_LO)
         |=> (ch1_dim_width[7:0] == $past(reg_wdata))
             && (ch1_dim_width[9:8] == $past(ch1_dim_width[9:8]));
   endproperty
   a_dim_width_low: assert property (p_dim_width_low)
      else $error("channel 1 dimming width low write misplaced");

   property p_dim_ch2_high;
      @(posedge clock) disable iff (sys_rst)
      (reg_wr_en && reg_addr == `LEDCTL_ADDR_CH2_DIM_HI)
         |=> (ch2_dim_width[9:8] == $past(reg_wdata[1:0])) && (reg_value[10][7:2] == 6'h00);
   endproperty
   a_dim_ch2_high: assert property (p_dim_ch2_high)
      else $error("channel 2 dimming width high write misplaced");

   property p_rdata_holds;
      @(posedge clock) disable iff (sys_rst)
      !reg_rd_en |=> $stable(reg_rdata);
   endproperty
   a_rdata_holds: assert property (p_rdata_holds)
      else $error("read data changed without a read");

   property p_unmapped_zero;
      @(posedge clock) disable iff (sys_rst)
      (reg_rd_en && ((reg_addr < `LEDCTL_ADDR_STATUS3) || (reg_addr > `LEDCTL_ADDR_CH2_ON)))
         |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped offset did not read as zero");

   property p_flag_holds;
      @(posedge clock) disable iff (sys_rst)
      (thermal_warn_flag && !(reg_rd_en && reg_addr == `LEDCTL_ADDR_STATUS3))
         |=> thermal_warn_flag;
   endproperty
   a_flag_holds: assert property (p_flag_holds)
      else $error("thermal flag dropped without a status read");

endmodule // led_driver_control_regs

/* File: spi_host_model.sv */
// host-side model that issues byte reads and writes on the register port
`timescale 1ns/1ps

module spi_host_model (
   input wire logic clock,
   input wire logic sys_rst,
   output logic [7:0] reg_addr,
   output logic reg_wr_en,
   output logic reg_rd_en,
   output ledctl_pkg::byte_t reg_wdata
);
   import ledctl_pkg::*;

   // ------------------------------------------------------------------
   // request queue: {write, read, address, data}; 00 kind is an idle slot
   // ------------------------------------------------------------------
   logic [17:0] req_q[$];
   logic [17:0] req;

   initial begin
      reg_addr = 8'h00;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_wdata = 8'h00;
   end

   // one request per cycle, so back-to-back traffic comes from queue depth;
   // idle lines flip so a stale address or data can never pass for valid
   always @(negedge clock) begin
      req = 18'h00000;
      if (!sys_rst && req_q.size() != 0) begin
         req = req_q.pop_front();
      end
      if (req[17:16] != 2'b00) begin
         reg_wr_en <= req[17];
         reg_rd_en <= req[16];
         reg_addr <= req[15:8];
         reg_wdata <= req[7:0];
      end else begin
         reg_wr_en <= 1'b0;
         reg_rd_en <= 1'b0;
         reg_addr <= ~reg_addr;
         reg_wdata <= ~reg_wdata;
      end
   end

   task wr(input byte_t a, input byte_t d);
      req_q.push_back({2'b10, a, d});
   endtask

   task rd(input byte_t a);
      req_q.push_back({2'b01, a, ~a});
   endtask

   // wait until every request has been taken and its effect has settled;
   // a hang here is caught by the bench watchdog, which fails the run
   task drain;
      while (req_q.size() != 0) begin
         @(negedge clock);
      end
      repeat (2) @(negedge clock);
   endtask
endmodule // spi_host_model

/* File: testbench.sv */
// self-checking testbench of the led driver control register bank
`timescale 1ns/1ps
`include "ledctl_map.svh"

module testbench;
   import ledctl_pkg::*;

   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr;
   logic reg_wr_en;
   logic reg_rd_en;
   byte_t reg_wdata;
   byte_t reg_rdata;
   logic temp_valid = 1'b0;
   logic [9:0] temp_adc = 10'h000;
   logic thermal_warn_flag;
   logic sleep_active;
   logic [9:0] ch1_current_set_value;
   logic [9:0] ch2_current_set_value;
   logic [2:0] dimming_clock_divider;
   logic [9:0] ch1_dim_width;
   logic [9:0] ch2_dim_width;
   logic [5:0] ch1_on_time;
   logic [5:0] ch2_on_time;
   int error_cnt = 0;
   int compares = 0;
   int seed = 97;
   logic [15:0] exp_q[$];
   logic [15:0] ent;
   logic rd_seen = 1'b0;
   logic sleep_exp;
   byte_t lim;
   byte_t d;
   byte_t val[13];
   byte_t addr_tab[13] = '{`LEDCTL_ADDR_TW_LIMIT, `LEDCTL_ADDR_SLEEP, `LEDCTL_ADDR_CH1_CUR_LO,
      `LEDCTL_ADDR_CH1_CUR_HI, `LEDCTL_ADDR_CH2_CUR_LO, `LEDCTL_ADDR_CH2_CUR_HI,
      `LEDCTL_ADDR_DIM_DIV, `LEDCTL_ADDR_CH1_DIM_LO, `LEDCTL_ADDR_CH1_DIM_HI,
      `LEDCTL_ADDR_CH2_DIM_LO, `LEDCTL_ADDR_CH2_DIM_HI, `LEDCTL_ADDR_CH1_ON, `LEDCTL_ADDR_CH2_ON};
   byte_t mask_tab[13] = '{8'hff, 8'h03, 8'h03, 8'hff, 8'h03, 8'hff, 8'h07, 8'hff, 8'h03,
      8'hff, 8'h03, 8'h3f, 8'h3f};
   byte_t rst_tab[13] = '{8'h8a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h07, 8'h07};
   sleep_cmd_e codes[7] = '{SLEEP_ENTER, SLEEP_HOLD_A, SLEEP_HOLD_B, SLEEP_EXIT, SLEEP_HOLD_B,
      SLEEP_HOLD_A, SLEEP_ENTER};

   always #2.5 clock = ~clock;

   spi_host_model host (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata));

   led_driver_control_regs DUT (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .temp_valid(temp_valid), .temp_adc(temp_adc),
      .thermal_warn_flag(thermal_warn_flag), .sleep_active(sleep_active),
      .ch1_current_set_value(ch1_current_set_value),
      .ch2_current_set_value(ch2_current_set_value),
      .dimming_clock_divider(dimming_clock_divider), .ch1_dim_width(ch1_dim_width),
      .ch2_dim_width(ch2_dim_width), .ch1_on_time(ch1_on_time), .ch2_on_time(ch2_on_time));

   // ------------------------------------------------------------------
   // comparison, verdict and read-data monitor
   // ------------------------------------------------------------------
   task check(input string what, input logic [9:0] seen, input logic [9:0] expv);
      compares++;
      if (seen !== expv) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, expv, seen);
      end
   endtask

   task print_verdict;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task exp_rd(input byte_t a, input byte_t v);
      host.rd(a);
      exp_q.push_back({a, v});
   endtask

   // read data stands right after the taking edge, so look half a cycle later
   always @(posedge clock) rd_seen <= reg_rd_en;
   always @(negedge clock) begin
      if (rd_seen && !sys_rst) begin
         ent = (exp_q.size() != 0) ? exp_q.pop_front() : 16'hffff;
         check($sformatf("rdata at %h", ent[15:8]), {2'b00, reg_rdata}, {2'b00, ent[7:0]});
      end
   end

   task check_outs;
      check("ch1_current", ch1_current_set_value, {val[3], val[2][1:0]});
      check("ch2_current", ch2_current_set_value, {val[5], val[4][1:0]});
      check("divider", {7'h00, dimming_clock_divider}, {7'h00, val[6][2:0]});
      check("ch1_dim", ch1_dim_width, {val[8][1:0], val[7]});
      check("ch2_dim", ch2_dim_width, {val[10][1:0], val[9]});
      check("ch1_on", {4'h0, ch1_on_time}, {4'h0, val[11][5:0]});
      check("ch2_on", {4'h0, ch2_on_time}, {4'h0, val[12][5:0]});
      check("sleep", {9'h000, sleep_active}, {9'h000, sleep_exp});
   endtask

   // hold reset four cycles, then every offset and output shows its reset value
   task reset_check;
      sys_rst = 1'b1;
      repeat (4) @(negedge clock);
      sys_rst = 1'b0;
      for (int i = 0; i < 13; i++) exp_rd(addr_tab[i], rst_tab[i]);
      exp_rd(`LEDCTL_ADDR_STATUS3, 8'h00);
      exp_rd(8'h13, 8'h00);
      exp_rd(8'hff, 8'h00);
      host.drain();
      val = rst_tab;
      sleep_exp = 1'b0;
      check_outs();
      check("warn_flag", {9'h000, thermal_warn_flag}, 10'h000);
   endtask

   // a hung handshake must still end the run through the same verdict
   initial begin
      #200000;
      error_cnt++;
      print_verdict();
   end

   initial begin
      // reset contents, status and unmapped offsets
      reset_check();
      $display("test reset_values done");
      // random bytes into every register; round 1 writes back to back
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < 13; i++) begin
            d = byte_t'($random(seed));
            host.wr(addr_tab[i], d);
            val[i] = d & mask_tab[i];
            if (i == 1 && val[1][1:0] < 2) sleep_exp = val[1][0];
            if (r != 1) host.drain();
            if (r != 1) check_outs();
         end
         host.wr(8'h13, byte_t'($random(seed)));
         for (int i = 0; i < 13; i++) exp_rd(addr_tab[i], val[i]);
         host.drain();
         check_outs();
      end
      $display("test random_access done");
      // every sleep code, with noise in the reserved bits
      for (int i = 0; i < 7; i++) begin
         d = byte_t'($random(seed));
         host.wr(`LEDCTL_ADDR_SLEEP, {d[7:2], codes[i]});
         exp_rd(`LEDCTL_ADDR_SLEEP, {6'h00, codes[i]});
         if (codes[i] == SLEEP_EXIT) sleep_exp = 1'b0;
         if (codes[i] == SLEEP_ENTER) sleep_exp = 1'b1;
         host.drain();
         check("sleep", {9'h000, sleep_active}, {9'h000, sleep_exp});
      end
      $display("test sleep_codes done");
      // reset again in mid-run, with sleep entered and every register written
      reset_check();
      $display("test mid_reset done");
      // thermal compare at the boundary, then clear on status read
      lim = byte_t'($random(seed));
      if (lim > 8'hfd) lim = 8'h80;
      d = byte_t'($random(seed));
      // each write is read back in the very next cycle
      host.wr(`LEDCTL_ADDR_TW_LIMIT, lim);
      exp_rd(`LEDCTL_ADDR_TW_LIMIT, lim);
      host.wr(`LEDCTL_ADDR_CH2_CUR_LO, d);
      exp_rd(`LEDCTL_ADDR_CH2_CUR_LO, d & 8'h03);
      host.drain();
      temp_adc = {lim, 2'b11};
      temp_valid = 1'b1;
      @(negedge clock);
      temp_valid = 1'b0;
      temp_adc = {lim + 8'h01, 2'b00};
      @(negedge clock);
      check("warn_equal", {9'h000, thermal_warn_flag}, 10'h000);
      @(negedge clock);
      check("warn_invalid", {9'h000, thermal_warn_flag}, 10'h000);
      temp_valid = 1'b1;
      @(negedge clock);
      temp_valid = 1'b0;
      @(negedge clock);
      check("warn_over", {9'h000, thermal_warn_flag}, 10'h001);
      exp_rd(`LEDCTL_ADDR_STATUS3, 8'h08);
      exp_rd(`LEDCTL_ADDR_STATUS3, 8'h00);
      host.drain();
      check("warn_cleared", {9'h000, thermal_warn_flag}, 10'h000);
      $display("test thermal_warning done");
      print_verdict();
   end
endmodule // testbench
